// File: design/lss_consts.svh
// constants of the line scanner status flag block
`ifndef LSS_CONSTS_SVH
`define LSS_CONSTS_SVH
// ==================================================
// geometry
`define LSS_NLINES 32
`define LSS_SYNC_W 10
// ==================================================
// secondary status bit positions
`define LSS_SCF_ERR 0
`define LSS_SCF_ILK 1
`define LSS_SCF_OVR 2
`define LSS_SCF_MDM 3
`define LSS_SCF_CAR 4
`define LSS_SCF_FLG 5
`define LSS_SCF_PGM 6
`define LSS_SCF_PAD 7
`define LSS_SCF_W1C 8'h2f
`define LSS_SCF_RST 8'h00
// ==================================================
// primary line states
`define LSS_PCF_IDLE 4'h0
`define LSS_PCF_MON 4'h4
`define LSS_PCF_RXI 4'h6
`define LSS_PCF_RX 4'h7
`define LSS_PCF_TXI 4'h8
`define LSS_PCF_TX 4'h9
// ==================================================
// line codes and patterns
`define LSS_LCD_MONF 4'h8
`define LSS_LCD_SDLC 4'h9
`define LSS_LCD_EBC 4'hc
`define LSS_LCD_ASC 4'hd
`define LSS_FLAG 8'h7e
`define LSS_SYN_EBC 8'h32
`define LSS_SYN_ASC 8'h16
`define LSS_ONES_FORCE 3'h1
`define LSS_ONES_INS 3'h5
`define LSS_ONES_ABT 3'h6
`endif

// File: design/lss_pkg.sv
// types shared by the line scanner status flag block
package lss_pkg;
	typedef enum logic [1:0] {
		LSS_CMD_NONE = 2'h0,
		LSS_CMD_SCF  = 2'h1,
		LSS_CMD_PCF  = 2'h2,
		LSS_CMD_PDF  = 2'h3
	} lss_cmd_e;
	typedef logic [4:0] lss_line_t;
	typedef struct packed {
		lss_line_t  line;
		logic [7:0] data;
	} lss_char_s;
endpackage

// File: design/lss_stream_if.sv
// valid/ready character stream between scanner modules
`timescale 1ns/1ns
`default_nettype none
interface lss_stream_if;
	import lss_pkg::*;
	lss_char_s data;
	logic      valid;
	logic      ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// File: design/lss_sync.sv
// two-flop synchroniser bank for the line interface pins
`timescale 1ns/1ns
`default_nettype none
`include "lss_consts.svh"
module lss_sync (
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire logic [`LSS_SYNC_W-1:0] d,
	output logic      [`LSS_SYNC_W-1:0] q
);
	logic [`LSS_SYNC_W-1:0] meta_ff;
	// ==================================================
	// one pair of flops per pin; the first stage feeds only the second
	for (genvar i = 0; i < `LSS_SYNC_W; i++) begin : g_bit
		always_ff @(posedge clk) begin
			if (reset) begin
				meta_ff[i] <= 1'b0;
				q[i]       <= 1'b0;
			end else begin
				meta_ff[i] <= d[i];
				q[i]       <= meta_ff[i];
			end
		end
	end
endmodule
`default_nettype wire

// File: design/lss_fifo2.sv
// two-entry character buffer with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module lss_fifo2 (
	input  wire logic clk,
	input  wire logic reset,
	lss_stream_if.snk in_s,
	lss_stream_if.src out_s
);
	import lss_pkg::*;
	lss_char_s  mem_ff [2];
	logic       wp_ff;
	logic       rp_ff;
	logic [1:0] cnt_ff;
	logic       push;
	logic       pop;
	// ==================================================
	// honest full/empty from the occupancy count
	assign in_s.ready  = (cnt_ff != 2'h2);
	assign out_s.valid = (cnt_ff != 2'h0);
	assign out_s.data  = mem_ff[rp_ff];
	assign push        = in_s.valid & in_s.ready;
	assign pop         = out_s.valid & out_s.ready;
	// storage and pointers
	always_ff @(posedge clk) begin
		if (reset) begin
			wp_ff  <= 1'b0;
			rp_ff  <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			if (push) begin
				mem_ff[wp_ff] <= in_s.data;
				wp_ff         <= ~wp_ff;
			end
			if (pop)
				rp_ff <= ~rp_ff;
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule
`default_nettype wire

// File: design/lss_top.sv
// per-line receive assembly and secondary status flags of the scanner
`timescale 1ns/1ns
`default_nettype none
`include "lss_consts.svh"
module lss_top (
	input  wire logic              CLK,
	input  wire logic              RESET,
	input  wire logic              LINE_CLK,
	input  wire logic              LINE_RXD,
	input  wire logic              LINE_DSR,
	input  wire logic              LINE_CTS,
	input  wire logic              LINE_CD,
	input  wire lss_pkg::lss_line_t LINE_ADDR,
	input  wire lss_pkg::lss_cmd_e  PROG_CMD,
	input  wire lss_pkg::lss_line_t PROG_ADDR,
	input  wire logic [7:0]        PROG_DATA,
	output logic      [7:0]        PROG_SCF,
	output logic      [3:0]        PROG_PCF,
	output logic                   TX_BIT,
	output logic                   L2_REQ,
	output lss_pkg::lss_line_t      L2_LINE,
	output logic                   CHAR_VALID,
	input  wire logic              CHAR_READY,
	output logic      [7:0]        CHAR_DATA,
	output lss_pkg::lss_line_t      CHAR_LINE
);
	import lss_pkg::*;

	// ==================================================
	// per-line control words
	logic [7:0] sdf_ff  [`LSS_NLINES];
	logic [7:0] hist_ff [`LSS_NLINES];
	logic [7:0] pdf_ff  [`LSS_NLINES];
	logic [7:0] scf_ff  [`LSS_NLINES];
	logic [3:0] pcf_ff  [`LSS_NLINES];
	logic [3:0] lcd_ff  [`LSS_NLINES];
	logic [3:0] cnt_ff  [`LSS_NLINES];
	logic [2:0] ones_ff [`LSS_NLINES];

	logic [`LSS_SYNC_W-1:0] pins_s;
	logic       clk_s, rxd_s, dsr_s, cts_s, cd_s;
	lss_line_t  la;
	logic       clk_d_ff, pend_ff, go, edge_seen;
	logic       tx_ff, l2_ff, la_q_ff;
	lss_line_t  l2_line_ff, la_ff, pa_ff;
	logic [7:0] scf_rd_ff;
	logic [3:0] pcf_rd_ff;

	// ==================================================
	// pin synchronisers; the address is expected stable around each bit edge
	lss_sync u_sync (
		.clk   (CLK),
		.reset (RESET),
		.d     ({LINE_ADDR, LINE_CD, LINE_CTS, LINE_DSR, LINE_RXD, LINE_CLK}),
		.q     (pins_s)
	);
	assign {la, cd_s, cts_s, dsr_s, rxd_s, clk_s} = pins_s;
	assign edge_seen = clk_s & ~clk_d_ff;

	// ==================================================
	// character buffer toward the program side
	lss_stream_if in_if ();
	lss_stream_if out_if ();
	lss_fifo2 u_buf (
		.clk   (CLK),
		.reset (RESET),
		.in_s  (in_if.snk),
		.out_s (out_if.src)
	);
	assign out_if.ready = CHAR_READY;
	assign CHAR_VALID   = out_if.valid;
	assign CHAR_DATA    = out_if.data.data;
	assign CHAR_LINE    = out_if.data.line;

	// a bit request waits while the program owns the words; only the bit that
	// finishes a character waits for buffer room, so a stalled reader costs no
	// line bits of the character still being assembled
	assign go = pend_ff & (PROG_CMD == LSS_CMD_NONE) & (in_if.ready | ~deliver);

	// ==================================================
	// decoding used in several places
	function automatic logic is_ss(input logic [3:0] c);
		is_ss = (c == 4'h0) | (c == 4'h2) | ((c >= 4'h4) & (c <= 4'h7));
	endfunction
	function automatic logic is_sdlc(input logic [3:0] c);
		is_sdlc = (c == `LSS_LCD_MONF) | (c == `LSS_LCD_SDLC);
	endfunction
	function automatic logic [3:0] data_bits(input logic [3:0] c);
		case (c)
			4'h0: data_bits = 4'h6;
			4'h2: data_bits = 4'h5;
			4'h4, 4'h5: data_bits = 4'h7;
			default: data_bits = 4'h8;
		endcase
	endfunction

	// ==================================================
	// next values of the addressed line's word for one bit service
	logic [7:0] cur_scf, nxt_sdf, nxt_hist, nxt_pdf, nxt_scf, hist_sh, ch;
	logic [3:0] cur_pcf, cur_lcd, nxt_pcf, nxt_lcd, nxt_cnt, db;
	logic [2:0] nxt_ones, ones_o;
	logic       s0, s2, s3, s5, c5, want_l2, flag, abort, deliver, nxt_tx;
	logic       try_ilk, set_ilk, err_any;

	always_comb begin
		cur_scf  = scf_ff[la];
		cur_pcf  = pcf_ff[la];
		cur_lcd  = lcd_ff[la];
		ones_o   = ones_ff[la];
		nxt_sdf  = sdf_ff[la];
		nxt_cnt  = cnt_ff[la];
		nxt_pdf  = pdf_ff[la];
		nxt_pcf  = cur_pcf;
		nxt_lcd  = cur_lcd;
		nxt_ones = ones_o;
		nxt_tx   = tx_ff;
		hist_sh  = {rxd_s, hist_ff[la][7:1]}; // lsb first, like the data field
		nxt_hist = hist_ff[la];
		db       = data_bits(cur_lcd);
		ch       = 8'h00;
		s0 = 1'b0; s2 = 1'b0; s3 = 1'b0; s5 = 1'b0; c5 = 1'b0;
		want_l2 = 1'b0; flag = 1'b0; abort = 1'b0; deliver = 1'b0;
		// modem checks on every service of the line
		if (~dsr_s && cur_pcf >= 4'h5 && cur_pcf <= 4'hd)
			s3 = 1'b1;
		if (~cts_s && (cur_pcf == 4'h9 || cur_pcf == 4'ha || cur_pcf == 4'hb || cur_pcf == 4'hd))
			s3 = 1'b1;
		if (is_ss(cur_lcd) && cur_pcf == `LSS_PCF_RX && cur_scf[`LSS_SCF_PAD] && ~cd_s)
			s3 = 1'b1;
		if (is_ss(cur_lcd) && cur_pcf == `LSS_PCF_RX) begin
			// start-stop receive: hunt start, shift data lsb first, check stop
			if (nxt_cnt == 4'h0) begin
				if (~rxd_s)
					nxt_cnt = 4'h1;
			end else if (nxt_cnt <= db) begin
				nxt_sdf = {rxd_s, nxt_sdf[7:1]};
				nxt_cnt = nxt_cnt + 4'h1;
			end else begin
				nxt_cnt = 4'h0;
				if (~rxd_s)
					s0 = 1'b1;
				else begin
					ch      = nxt_sdf >> (4'h8 - db);
					deliver = 1'b1;
					want_l2 = 1'b1;
				end
			end
		end else if (is_sdlc(cur_lcd) && cur_pcf >= `LSS_PCF_MON && cur_pcf <= `LSS_PCF_RX) begin
			// bit-oriented receive: flag and abort hunt, zero deletion
			nxt_hist = hist_sh;
			nxt_ones = rxd_s ? ((ones_o == 3'h7) ? ones_o : ones_o + 3'h1) : 3'h0;
			abort    = rxd_s && ones_o == `LSS_ONES_ABT && cur_pcf >= `LSS_PCF_RXI;
			flag     = hist_sh == `LSS_FLAG;
			if (abort) begin
				s0      = 1'b1;
				nxt_cnt = 4'h0;
			end else if (flag) begin
				s5      = 1'b1;
				nxt_lcd = `LSS_LCD_SDLC;
				if (cur_pcf == `LSS_PCF_RX && cnt_ff[la] != 4'h7)
					s2 = 1'b1;
				if (cur_pcf != `LSS_PCF_RXI) begin
					nxt_pcf = `LSS_PCF_RXI;
					want_l2 = 1'b1;
				end
				nxt_cnt = 4'h0;
				nxt_sdf = 8'h00;
			end else if (cur_pcf == `LSS_PCF_RX && !(~rxd_s && ones_o == `LSS_ONES_INS)) begin
				nxt_sdf = {rxd_s, nxt_sdf[7:1]};
				nxt_cnt = nxt_cnt + 4'h1;
				if (nxt_cnt == 4'h8) begin
					nxt_cnt = 4'h0;
					ch      = nxt_sdf;
					deliver = 1'b1;
					want_l2 = 1'b1;
				end
			end
		end else if ((cur_lcd == `LSS_LCD_EBC || cur_lcd == `LSS_LCD_ASC)
				&& cur_pcf >= `LSS_PCF_MON && cur_pcf <= `LSS_PCF_RX) begin
			// synchronous receive: only the first sync character sets phase
			nxt_hist = hist_sh;
			if (cur_pcf != `LSS_PCF_RX) begin
				if (hist_sh == ((cur_lcd == `LSS_LCD_EBC) ? `LSS_SYN_EBC : `LSS_SYN_ASC)) begin
					nxt_pcf = `LSS_PCF_RX;
					nxt_cnt = 4'h0;
					nxt_sdf = 8'h00;
				end
			end else begin
				nxt_sdf = {rxd_s, nxt_sdf[7:1]};
				nxt_cnt = nxt_cnt + 4'h1;
				if (nxt_cnt == 4'h8) begin
					nxt_cnt = 4'h0;
					ch      = nxt_sdf;
					deliver = 1'b1;
					want_l2 = 1'b1;
				end
			end
		end else if (is_ss(cur_lcd) && cur_pcf == `LSS_PCF_TX) begin
			// start-stop transmit: a space seen at tag time is a break
			if (nxt_cnt == 4'h0 && ~rxd_s)
				s0 = 1'b1;
		end else if (is_sdlc(cur_lcd) && cur_pcf == `LSS_PCF_TXI) begin
			if (cts_s) begin
				s5      = 1'b1;
				nxt_pcf = `LSS_PCF_TX;
			end
		end else if (is_sdlc(cur_lcd) && cur_pcf >= `LSS_PCF_TX && cur_pcf <= 4'hd
				&& cur_pcf != 4'hb) begin
			// bit-oriented transmit with zero insertion
			if (nxt_cnt == 4'h0) begin
				nxt_sdf = nxt_pdf; // tag: parallel to serial
				nxt_cnt = 4'h8;
				want_l2 = 1'b1;
				if (cur_scf[`LSS_SCF_PAD])
					s5 = 1'b1;
				else
					c5 = 1'b1;
			end else if (ones_o == `LSS_ONES_INS && !cur_scf[`LSS_SCF_FLG]) begin
				nxt_tx   = 1'b0;
				nxt_ones = 3'h0;
			end else begin
				nxt_tx   = nxt_sdf[0];
				nxt_ones = nxt_sdf[0] ? ones_o + 3'h1 : 3'h0;
				nxt_sdf  = {1'b0, nxt_sdf[7:1]};
				nxt_cnt  = nxt_cnt - 4'h1;
			end
			if ((cur_scf[`LSS_SCF_FLG] & ~c5) | s5)
				nxt_ones = `LSS_ONES_FORCE;
		end
		// interlock and status merge
		err_any = s0 | s2 | s3;
		try_ilk = want_l2 & ~flag & ~abort;
		if (try_ilk && !err_any && cur_scf[`LSS_SCF_ILK])
			s2 = 1'b1;
		err_any = s0 | s2 | s3;
		set_ilk = try_ilk & ~err_any;
		nxt_scf = cur_scf;
		nxt_scf[`LSS_SCF_ERR] = cur_scf[`LSS_SCF_ERR] | s0;
		nxt_scf[`LSS_SCF_OVR] = cur_scf[`LSS_SCF_OVR] | s2;
		nxt_scf[`LSS_SCF_MDM] = cur_scf[`LSS_SCF_MDM] | s3;
		nxt_scf[`LSS_SCF_CAR] = cd_s;
		nxt_scf[`LSS_SCF_FLG] = s5 | (cur_scf[`LSS_SCF_FLG] & ~c5);
		if (err_any || abort)
			nxt_scf[`LSS_SCF_ILK] = 1'b0;
		else if (set_ilk)
			nxt_scf[`LSS_SCF_ILK] = 1'b1;
		if (deliver)
			nxt_pdf = ch;
	end

	assign in_if.valid     = go & deliver;
	assign in_if.data.line = la;
	assign in_if.data.data = ch;

	// ==================================================
	// bit request capture from the sampled line clock
	always_ff @(posedge CLK) begin
		if (RESET) begin
			clk_d_ff <= 1'b0;
			pend_ff  <= 1'b0;
		end else begin
			clk_d_ff <= clk_s;
			if (edge_seen)
				pend_ff <= 1'b1;
			else if (go)
				pend_ff <= 1'b0;
		end
	end

	// ==================================================
	// control word store; one line changes per cycle, program first
	always_ff @(posedge CLK) begin
		if (RESET) begin
			for (int i = 0; i < `LSS_NLINES; i++) begin
				scf_ff[i]  <= `LSS_SCF_RST;
				pcf_ff[i]  <= `LSS_PCF_IDLE;
				lcd_ff[i]  <= 4'h0;
				cnt_ff[i]  <= 4'h0;
				ones_ff[i] <= 3'h0;
				sdf_ff[i]  <= 8'h00;
				hist_ff[i] <= 8'h00;
				pdf_ff[i]  <= 8'h00;
			end
		end else if (PROG_CMD == LSS_CMD_SCF) begin
			// write one clears 0-3 and 5; 6 and 7 take the written value
			scf_ff[PROG_ADDR] <= {PROG_DATA[7:6], scf_ff[PROG_ADDR][5:0]
				& ~(PROG_DATA[5:0] & 6'(`LSS_SCF_W1C))};
		end else if (PROG_CMD == LSS_CMD_PCF) begin
			pcf_ff[PROG_ADDR]  <= PROG_DATA[7:4];
			lcd_ff[PROG_ADDR]  <= PROG_DATA[3:0];
			cnt_ff[PROG_ADDR]  <= 4'h0;
			ones_ff[PROG_ADDR] <= 3'h0;
			hist_ff[PROG_ADDR] <= 8'h00;
		end else if (PROG_CMD == LSS_CMD_PDF) begin
			pdf_ff[PROG_ADDR] <= PROG_DATA;
		end else if (go) begin
			scf_ff[la]  <= nxt_scf;
			pcf_ff[la]  <= nxt_pcf;
			lcd_ff[la]  <= nxt_lcd;
			cnt_ff[la]  <= nxt_cnt;
			ones_ff[la] <= nxt_ones;
			sdf_ff[la]  <= nxt_sdf;
			hist_ff[la] <= nxt_hist;
			pdf_ff[la]  <= nxt_pdf;
		end
	end

	// ==================================================
	// registered outputs: serial bit, level two request, program reads
	always_ff @(posedge CLK) begin
		if (RESET) begin
			tx_ff      <= 1'b1;
			l2_ff      <= 1'b0;
			l2_line_ff <= 5'h00;
			scf_rd_ff  <= 8'h00;
			pcf_rd_ff  <= 4'h0;
			la_ff      <= 5'h00;
			pa_ff      <= 5'h00;
			la_q_ff    <= 1'b0;
		end else begin
			if (go)
				tx_ff <= nxt_tx;
			l2_ff      <= go & want_l2;
			l2_line_ff <= la;
			scf_rd_ff  <= scf_ff[PROG_ADDR];
			pcf_rd_ff  <= pcf_ff[PROG_ADDR];
			la_ff      <= la;
			pa_ff      <= PROG_ADDR;
			la_q_ff    <= go;
		end
	end
	assign TX_BIT   = tx_ff;
	assign L2_REQ   = l2_ff;
	assign L2_LINE  = l2_line_ff;
	assign PROG_SCF = scf_rd_ff;
	assign PROG_PCF = pcf_rd_ff;

	// ==================================================
	// checks on the status flag behaviour
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	stop_check_a: assert property (go && s0 && is_ss(cur_lcd) && cur_pcf == `LSS_PCF_RX
		|=> scf_ff[la_ff][`LSS_SCF_ERR] && !L2_REQ)
		else $error("stop bit space did not set error bit");
	ilk_clear_a: assert property (go && err_any |=> !scf_ff[la_ff][`LSS_SCF_ILK])
		else $error("error did not clear interlock");
	w1c_clear_a: assert property (PROG_CMD == LSS_CMD_SCF && PROG_DATA[0]
		|=> !scf_ff[pa_ff][`LSS_SCF_ERR] ##1 !PROG_SCF[`LSS_SCF_ERR] || la_q_ff)
		else $error("write one did not clear bit zero");
	overrun_a: assert property (go && try_ilk && !(s0 | s3) && cur_scf[`LSS_SCF_ILK]
		|=> scf_ff[la_ff][`LSS_SCF_OVR] && !scf_ff[la_ff][`LSS_SCF_ILK])
		else $error("second request did not flag overrun");
	carrier_a: assert property (go |=> scf_ff[la_ff][`LSS_SCF_CAR] == $past(cd_s))
		else $error("carrier bit does not follow carrier");
	flag_state_a: assert property (go && flag && !abort && cur_pcf == `LSS_PCF_RX
		|=> pcf_ff[la_ff] == `LSS_PCF_RXI && L2_REQ && scf_ff[la_ff][`LSS_SCF_FLG])
		else $error("flag in receive did not move to six with request");
	cts_start_a: assert property (go && is_sdlc(cur_lcd) && cur_pcf == `LSS_PCF_TXI && cts_s
		|=> pcf_ff[la_ff] == `LSS_PCF_TX && scf_ff[la_ff][`LSS_SCF_FLG])
		else $error("clear to send did not start transmit");
	ones_hold_a: assert property (go && nxt_scf[`LSS_SCF_FLG] && is_sdlc(cur_lcd)
		&& cur_pcf >= `LSS_PCF_TX |=> ones_ff[la_ff] == `LSS_ONES_FORCE)
		else $error("ones counter not held while bit five set");
	deliver_a: assert property (go && deliver |-> ##[1:2] CHAR_VALID)
		else $error("assembled character not offered");
	dsr_check_a: assert property (go && !dsr_s && cur_pcf inside {[4'h5:4'hd]}
		|=> scf_ff[la_ff][`LSS_SCF_MDM])
		else $error("lost data set ready not flagged");

	char_out_c: cover property (go && deliver ##[1:4] CHAR_VALID && CHAR_READY);
	flag_rx_c: cover property (go && flag && cur_pcf == `LSS_PCF_RX);
	overrun_c: cover property (go && try_ilk && cur_scf[`LSS_SCF_ILK]);
	stall_c: cover property (pend_ff && !in_if.ready);
endmodule
`default_nettype wire

// File: verif/lss_line_model.sv
// line interface model: bit service requests carrying received data
`timescale 1ns/1ns
`default_nettype none
module lss_line_model (
	output logic               line_clk,
	output logic               line_rxd,
	output lss_pkg::lss_line_t line_addr
);
	import lss_pkg::*;
	// ==================================================
	// idle: the bit clock stands low between frames, data rests at mark
	initial begin
		line_clk = 1'b0;
		line_rxd = 1'b1;
		line_addr = '0;
	end
	// ==================================================
	// one rise per bit; data changes 10 ns before the rise and holds
	// 70 ns after it, well past the scanner's service window
	task automatic frame(input lss_line_t a, input logic [15:0] bits, input int n);
		line_addr = a;
		for (int i = 0; i < n; i++) begin
			line_rxd = bits[i];
			#10 line_clk = 1'b1;
			#40 line_clk = 1'b0;
			#30;
		end
		line_rxd = 1'b1;
	endtask
endmodule
`default_nettype wire

// File: verif/line_scanner_status_flags_tb.sv
// self-checking bench of the line scanner status flag block
`timescale 1ns/1ns
`default_nettype none
`include "lss_consts.svh"
module line_scanner_status_flags_tb;
	import lss_pkg::*;
	logic       clk, reset, line_clk, line_rxd, dsr, cts, cd, char_ready;
	logic       tx_bit, l2_req, char_valid;
	lss_line_t  line_addr, prog_addr, l2_line, char_line, a;
	lss_cmd_e   prog_cmd;
	logic [7:0] prog_data, prog_scf, char_data, v, d;
	logic [3:0] prog_pcf;
	logic [3:0] codes [6] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7};
	int         bad_count, checks_done, l2_cnt, n;
	lss_char_s  rxq[$];

	lss_line_model line_m (.line_clk(line_clk), .line_rxd(line_rxd), .line_addr(line_addr));
	lss_top dut (
		.CLK(clk), .RESET(reset), .LINE_CLK(line_clk), .LINE_RXD(line_rxd),
		.LINE_DSR(dsr), .LINE_CTS(cts), .LINE_CD(cd), .LINE_ADDR(line_addr),
		.PROG_CMD(prog_cmd), .PROG_ADDR(prog_addr), .PROG_DATA(prog_data),
		.PROG_SCF(prog_scf), .PROG_PCF(prog_pcf), .TX_BIT(tx_bit), .L2_REQ(l2_req),
		.L2_LINE(l2_line), .CHAR_VALID(char_valid), .CHAR_READY(char_ready),
		.CHAR_DATA(char_data), .CHAR_LINE(char_line)
	);
	// ==================================================
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// collect delivered characters and count interrupt pulses
	always @(posedge clk) begin
		if (!reset && char_valid === 1'b1 && char_ready) rxq.push_back('{char_line, char_data});
		if (l2_req === 1'b1) l2_cnt++;
	end
	// ==================================================
	// expectations: data bits per start-stop code, right-justified mask
	function automatic int ss_width(input logic [3:0] c);
		case (c)
			4'h0: return 6;
			4'h2: return 5;
			4'h4, 4'h5: return 7;
			default: return 8;
		endcase
	endfunction
	function automatic logic [7:0] ss_mask(input int w);
		return 8'((1 << w) - 1);
	endfunction
	// ==================================================
	// shared tasks
	task automatic print_verdict();
		if (bad_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one command cycle, driven off the sampling edge
	task automatic cmd(input lss_cmd_e c, input lss_line_t ad, input logic [7:0] dt);
		@(negedge clk);
		prog_cmd = c;
		prog_addr = ad;
		prog_data = dt;
		@(negedge clk);
		prog_cmd = LSS_CMD_NONE;
	endtask
	// read view lags the store by the pipeline, so settle three cycles
	task automatic rd(input lss_line_t ad);
		@(negedge clk);
		prog_addr = ad;
		repeat (3) @(negedge clk);
	endtask
	// start bit, w data bits lsb first, then the given stop level
	task automatic ss(input logic [7:0] dt, input int w, input logic stop);
		line_m.frame(a, (16'(stop) << (w + 1)) | (16'(dt & ss_mask(w)) << 1), w + 2);
		repeat (4) @(negedge clk);
	endtask
	task automatic svc();
		line_m.frame(a, 16'hffff, 1);
		repeat (4) @(negedge clk);
	endtask
	task automatic pop(input logic [7:0] dt);
		lss_char_s c;
		for (int i = 0; i < 20 && rxq.size() == 0; i++) @(negedge clk);
		if (rxq.size() == 0) begin
			chk(8'h00, 8'h01);
		end else begin
			c = rxq.pop_front();
			chk(8'(c.line), 8'(a));
			chk(c.data, dt);
		end
	endtask
	// ==================================================
	// a hang counts as a mismatch
	initial begin
		#500000;
		bad_count++;
		print_verdict();
	end
	// ==================================================
	// main sequence
	initial begin
		bad_count = 0;
		checks_done = 0;
		l2_cnt = 0;
		reset = 1'b1;
		{dsr, cts, cd, char_ready} = 4'hf;
		prog_cmd = LSS_CMD_NONE;
		prog_addr = '0;
		prog_data = '0;
		void'($urandom(29));
		repeat (11) @(negedge clk);
		chk(prog_scf, `LSS_SCF_RST);
		chk({4'h0, prog_pcf}, 8'h00);
		chk({6'h0, tx_bit, l2_req}, 8'h02);
		@(negedge clk);
		reset = 1'b0;
		// every start-stop code, random character on a random line
		foreach (codes[k]) begin
			a = 5'($urandom_range(1, 30));
			d = 8'($urandom);
			n = ss_width(codes[k]);
			cmd(LSS_CMD_PCF, a, {`LSS_PCF_RX, codes[k]});
			cmd(LSS_CMD_SCF, a, `LSS_SCF_W1C);
			v = 8'(l2_cnt);
			ss(d, n, 1'b1);
			pop(d & ss_mask(n));
			chk(8'(l2_cnt), v + 8'h01);
			rd(a);
			chk(prog_scf & 8'h0f, 8'h02);
			cmd(LSS_CMD_SCF, a, 8'h00);
			rd(a);
			chk(prog_scf & 8'h0f, 8'h02);
			cmd(LSS_CMD_SCF, a, 8'h02);
			rd(a);
			chk(prog_scf & 8'h0f, 8'h00);
		end
		rd(5'h1f);
		chk(prog_scf & 8'h0f, 8'h00);
		// back to back characters without service: overrun
		a = 5'h0a;
		cmd(LSS_CMD_PCF, a, {`LSS_PCF_RX, 4'h6});
		cmd(LSS_CMD_SCF, a, `LSS_SCF_W1C);
		ss(8'h5a, 8, 1'b1);
		ss(8'ha5, 8, 1'b1);
		pop(8'h5a);
		pop(8'ha5);
		rd(a);
		chk(prog_scf & 8'h0f, 8'h04);
		// space where the stop bit belongs
		cmd(LSS_CMD_SCF, a, `LSS_SCF_W1C);
		ss(8'h3c, 8, 1'b0);
		rd(a);
		chk(prog_scf & 8'h0f, 8'h01);
		rxq.delete();
		// modem checks: data set ready lost in receive
		cmd(LSS_CMD_SCF, a, `LSS_SCF_W1C);
		dsr = 1'b0;
		svc();
		rd(a);
		chk(prog_scf & 8'h0f, 8'h08);
		dsr = 1'b1;
		// clear to send lost in transmit data
		cmd(LSS_CMD_PCF, a, {`LSS_PCF_TX, 4'h6});
		cmd(LSS_CMD_SCF, a, `LSS_SCF_W1C);
		cts = 1'b0;
		svc();
		rd(a);
		chk(prog_scf & 8'h08, 8'h08);
		cts = 1'b1;
		// space seen at transmit tag time
		cmd(LSS_CMD_SCF, a, `LSS_SCF_W1C);
		line_m.frame(a, 16'h0000, 1);
		rd(a);
		chk(prog_scf & 8'h0f, 8'h01);
		// carrier loss with the pad flag set, then carrier back
		cmd(LSS_CMD_PCF, a, {`LSS_PCF_RX, 4'h6});
		cmd(LSS_CMD_SCF, a, 8'haf);
		cd = 1'b0;
		svc();
		rd(a);
		chk(prog_scf & 8'h98, 8'h88);
		cd = 1'b1;
		cmd(LSS_CMD_SCF, a, `LSS_SCF_W1C);
		svc();
		rd(a);
		chk(prog_scf & 8'h98, 8'h10);
		// receiver stalls: two words buffered, third held, none lost
		char_ready = 1'b0;
		for (int i = 0; i < 3; i++) begin
			ss(8'(8'h41 + i), 8, 1'b1);
			cmd(LSS_CMD_SCF, a, 8'h02);
		end
		chk({7'h0, char_valid}, 8'h01);
		char_ready = 1'b1;
		for (int i = 0; i < 3; i++) pop(8'(8'h41 + i));
		chk({7'h0, char_valid}, 8'h00);
		// bit-oriented receive: flag, then abort, then clear bit five
		cmd(LSS_CMD_PCF, a, {`LSS_PCF_RX, `LSS_LCD_SDLC});
		cmd(LSS_CMD_SCF, a, `LSS_SCF_W1C);
		v = 8'(l2_cnt);
		line_m.frame(a, 16'(`LSS_FLAG), 8);
		rd(a);
		chk({4'h0, prog_pcf}, 8'h06);
		chk(prog_scf & 8'h22, 8'h20);
		chk(8'(l2_cnt), v + 8'h01);
		line_m.frame(a, 16'h007f, 7);
		rd(a);
		chk(prog_scf & 8'h03, 8'h01);
		cmd(LSS_CMD_SCF, a, 8'h20);
		rd(a);
		chk(prog_scf & 8'h20, 8'h00);
		// initial transmit: clear to send arrives
		cts = 1'b0;
		cmd(LSS_CMD_PCF, a, {`LSS_PCF_TXI, `LSS_LCD_SDLC});
		cmd(LSS_CMD_SCF, a, `LSS_SCF_W1C);
		cts = 1'b1;
		svc();
		rd(a);
		chk({4'h0, prog_pcf}, 8'h09);
		chk(prog_scf & 8'h20, 8'h20);
		// tag with the pad flag keeps bit five, so no zero follows five ones
		cmd(LSS_CMD_PDF, a, 8'hfe);
		cmd(LSS_CMD_SCF, a, 8'h80);
		svc();
		rd(a);
		chk(prog_scf & 8'h20, 8'h20);
		svc();
		chk({7'h0, tx_bit}, 8'h00);
		repeat (6) svc();
		chk({7'h0, tx_bit}, 8'h01);
		// synchronous receive: first sync character sets phase, then a character
		d = 8'($urandom);
		cmd(LSS_CMD_PCF, a, {`LSS_PCF_MON, `LSS_LCD_EBC});
		line_m.frame(a, 16'(`LSS_SYN_EBC), 8);
		rd(a);
		chk({4'h0, prog_pcf}, 8'h07);
		line_m.frame(a, 16'(d), 8);
		pop(d);
		print_verdict();
	end
endmodule
`default_nettype wire
